//--- logic/mpz_pkg.sv
// package: select codes, field layout, reset values and carriers for the zone/tag registers
package mpz_pkg;
  // special register select codes
  localparam logic [15:0] SEL_PROCESS_TAG  = 16'h1000;
  localparam logic [15:0] SEL_ZONE_OVERRIDE = 16'h1001;
  localparam logic [15:0] SEL_TRANS_LOW    = 16'h1002;
  localparam logic [15:0] SEL_TRANS_HIGH   = 16'h1003;
  localparam logic [15:0] SEL_ENTRY_INDEX  = 16'h1004;

  // geometry
  localparam int ENTRY_COUNT   = 64;
  localparam int INDEX_W       = 6;
  localparam int TAG_W         = 8;
  localparam int ZONE_COUNT_MAX = 16;

  // field positions, little-endian bit numbers (big-endian bits 24:31 = [7:0])
  localparam int TAG_LSB        = 0;
  localparam int ZONE_CHOICE_LSB = 4;   // big-endian 24:27
  localparam int WRITE_BIT      = 8;    // big-endian 23
  localparam int FETCH_BIT      = 9;    // big-endian 22
  localparam int VALID_BIT_HIGH = 6;    // valid flag position in high word

  // reset values
  localparam logic [TAG_W-1:0] TAG_RESET  = 8'h00;
  localparam logic [31:0]      ZONE_RESET = 32'h0000_0000;
  localparam logic [31:0]      LOW_INIT   = 32'h0000_0000;
  localparam logic [INDEX_W-1:0] INDEX_RESET = 6'h00;

  // access modes of translation_reg_access_param
  localparam int ACCESS_MIN   = 0;
  localparam int ACCESS_READ  = 1;
  localparam int ACCESS_WRITE = 2;
  localparam int ACCESS_FULL  = 3;

  // special register move request
  typedef struct packed {
    logic        to_special;    // move_to_special_op
    logic        from_special;  // move_from_special_op
    logic [15:0] special_reg_select;
    logic [31:0] wdata;
  } mpz_move_t;

  // permissions of one entry
  typedef struct packed {
    logic valid;
    logic store;
    logic fetch;
  } mpz_perm_t;
endpackage

//--- logic/mpz_zone_decode.sv
// zone override decoder: combines an entry's own permissions with one zone field
`timescale 1ns/10ps
`default_nettype none
module mpz_zone_decode (
  // selection
  input  wire logic             user_state_flag,
  input  wire logic [1:0]       zone_override_field,
  // permissions
  input  wire mpz_pkg::mpz_perm_t entry_perm,
  output var mpz_pkg::mpz_perm_t  eff_perm
);
  wire deny_all = user_state_flag && (zone_override_field == 2'h0);
  wire grant_all = user_state_flag ? (zone_override_field == 2'h3)
                                   : zone_override_field[1];

  // deny wins over the entry's valid flag; grant widens store and fetch only
  // one assignment for the whole struct keeps a single driver on the variable
  assign eff_perm = '{valid: entry_perm.valid && !deny_all,
                      store: !deny_all && (grant_all || entry_perm.store),
                      fetch: !deny_all && (grant_all || entry_perm.fetch)};
endmodule // mpz_zone_decode
`default_nettype wire

//--- logic/mpz_regs.sv
// process tag, zone override and translation buffer special register logic
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - process tag register exists only when manager level exceeds one.
// - select code 0x1000 reaches the process tag register on moves.
// - high word write stores the current process tag into the entry.
// - high word read loads the process tag from the addressed entry.
// - process tag is bits 24:31, read/write, resets to 0x00.
// - zone register exists only for level above one and zones above zero.
// - only zone fields for configured zones are implemented.
// - select 0x1001 reaches sixteen two-bit zone fields, reset zero.
// - user state: 00 denies, 01/10 use entry, 11 grants store and fetch.
// - privileged: 00/01 use entry, 10/11 grant store and fetch.
// - access to tag and zone registers follows the access parameter.
// - select 0x1002 reaches the low translation register.
// - low register accesses the entry chosen by the index register.
// - low register readability follows the access parameter.
// - low words are zero only at configuration load.
// - external and debugger resets leave buffer contents untouched.
// - entry zone choice field picks which zone field applies.
module mpz_regs #(
  parameter int memory_manager_level_param  = 3,
  parameter int zone_count_param            = 16,
  parameter int translation_reg_access_param = 3
) (
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 nrst,
  input  wire logic                 debugger_reset_input,
  // special register moves
  input  wire mpz_pkg::mpz_move_t   move_req,
  output logic [31:0]               move_rdata,
  output logic                      move_hit,
  // translation lookup
  input  wire logic                 user_state_flag,
  input  wire logic [mpz_pkg::INDEX_W-1:0] lookup_index,
  input  wire mpz_pkg::mpz_perm_t   lookup_entry_perm,
  output mpz_pkg::mpz_perm_t        lookup_perm,
  output logic [mpz_pkg::TAG_W-1:0] process_tag
);
  localparam bit HAS_TAG  = memory_manager_level_param > 1;
  localparam bit HAS_ZONE = HAS_TAG && (zone_count_param > 0);
  localparam int ZONES    = (zone_count_param > mpz_pkg::ZONE_COUNT_MAX) ?
                            mpz_pkg::ZONE_COUNT_MAX : zone_count_param;
  localparam bit CAN_READ = translation_reg_access_param != mpz_pkg::ACCESS_MIN;
  localparam bit CAN_WRITE = translation_reg_access_param == mpz_pkg::ACCESS_WRITE ||
                             translation_reg_access_param == mpz_pkg::ACCESS_FULL;

  // zone register field i lives at little-endian bits [31-2i -: 2]
  function automatic logic [1:0] zone_field(input logic [31:0] r, input logic [3:0] z);
    zone_field = r[31 - 2*z -: 2];
  endfunction

  // select decode
  wire sel_tag   = HAS_TAG  && move_req.special_reg_select == mpz_pkg::SEL_PROCESS_TAG;
  wire sel_zone  = HAS_ZONE && move_req.special_reg_select == mpz_pkg::SEL_ZONE_OVERRIDE;
  wire sel_low   = HAS_TAG  && move_req.special_reg_select == mpz_pkg::SEL_TRANS_LOW;
  wire sel_high  = HAS_TAG  && move_req.special_reg_select == mpz_pkg::SEL_TRANS_HIGH;
  wire sel_index = HAS_TAG  && move_req.special_reg_select == mpz_pkg::SEL_ENTRY_INDEX;
  wire wr_ok     = move_req.to_special && CAN_WRITE;
  wire rd_ok     = move_req.from_special && CAN_READ;

  wire wr_tag   = wr_ok && sel_tag;
  wire wr_zone  = wr_ok && sel_zone;
  wire wr_low   = wr_ok && sel_low;
  wire wr_high  = wr_ok && sel_high;
  wire wr_index = wr_ok && sel_index;
  wire rd_high  = rd_ok && sel_high;

  // state
  logic [mpz_pkg::TAG_W-1:0]   tag_q;
  logic [31:0]                 zone_q;
  logic [mpz_pkg::INDEX_W-1:0] entry_index_reg;
  // buffer storage has no reset branch so neither reset input disturbs it;
  // the declared value stands for the content after configuration load
  logic [31:0]                 low_mem [mpz_pkg::ENTRY_COUNT] =
                                 '{default: mpz_pkg::LOW_INIT};
  logic [31:0]                 high_mem [mpz_pkg::ENTRY_COUNT] =
                                 '{default: 32'h0000_0000};
  logic [mpz_pkg::TAG_W-1:0]   entry_process_tag [mpz_pkg::ENTRY_COUNT] =
                                 '{default: mpz_pkg::TAG_RESET};
  // a net, so each generated slice may drive its own bits
  wire  [31:0]                 next_zone;

  // only configured zone fields take writes; the rest stay zero
  genvar gz;
  generate
    for (gz = 0; gz < mpz_pkg::ZONE_COUNT_MAX; gz++) begin : g_zone
      if (gz < ZONES) begin : g_impl
        assign next_zone[31-2*gz -: 2] = move_req.wdata[31-2*gz -: 2];
      end else begin : g_none
        assign next_zone[31-2*gz -: 2] = 2'h0;
      end
    end
  endgenerate

  // tag register: written directly, or loaded by a high word read
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      tag_q <= mpz_pkg::TAG_RESET;
    end else if (wr_tag) begin
      tag_q <= move_req.wdata[mpz_pkg::TAG_LSB +: mpz_pkg::TAG_W];
    end else if (rd_high) begin
      tag_q <= entry_process_tag[entry_index_reg];
    end
  end

  // zone override register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      zone_q <= mpz_pkg::ZONE_RESET;
    end else if (wr_zone) begin
      zone_q <= next_zone;
    end
  end

  // entry index register
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      entry_index_reg <= mpz_pkg::INDEX_RESET;
    end else if (wr_index) begin
      entry_index_reg <= move_req.wdata[mpz_pkg::INDEX_W-1:0];
    end
  end

  // buffer writes through the index register
  always_ff @(posedge ref_clk) begin
    if (wr_low) begin
      low_mem[entry_index_reg] <= move_req.wdata;
    end
    if (wr_high) begin
      high_mem[entry_index_reg] <= move_req.wdata;
      entry_process_tag[entry_index_reg] <= tag_q;
    end
  end

  // read data mux; reserved and unmapped bits read zero
  wire [31:0] tag_word  = {24'h00_0000, tag_q};
  wire [31:0] low_word  = low_mem[entry_index_reg];
  wire [31:0] high_word = high_mem[entry_index_reg];
  wire [31:0] idx_word  = {26'h000_0000, entry_index_reg};
  wire [31:0] rsel = sel_tag   ? tag_word  :
                     sel_zone  ? zone_q    :
                     sel_low   ? low_word  :
                     sel_high  ? high_word :
                     sel_index ? idx_word  : 32'h0000_0000;

  // read data is registered so it stands one cycle after the request
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      move_rdata <= 32'h0000_0000;
      move_hit <= 1'b0;
    end else begin
      move_rdata <= rd_ok ? rsel : 32'h0000_0000;
      move_hit <= rd_ok && (sel_tag || sel_zone || sel_low || sel_high || sel_index);
    end
  end

  // lookup path: the entry's zone choice picks one override field
  wire [3:0] zone_choice_field = low_mem[lookup_index][mpz_pkg::ZONE_CHOICE_LSB +: 4];
  wire [1:0] picked = HAS_ZONE ? zone_field(zone_q, zone_choice_field) : 2'h1;

  mpz_zone_decode u_decode (
    .user_state_flag     (user_state_flag),
    .zone_override_field (picked),
    .entry_perm          (lookup_entry_perm),
    .eff_perm            (lookup_perm)
  );

  assign process_tag = tag_q;
endmodule // mpz_regs
`default_nettype wire

//--- verif/mpz_regs_asserts.sv
// checker: port-level timing and value relations of the zone/tag special registers
`timescale 1ns/10ps
`default_nettype none
module mpz_regs_asserts (
  // clock and reset
  input wire logic                          ref_clk,
  input wire logic                          nrst,
  // special register moves
  input wire mpz_pkg::mpz_move_t            move_req,
  input wire logic [31:0]                   move_rdata,
  input wire logic                          move_hit,
  // translation lookup
  input wire mpz_pkg::mpz_perm_t            lookup_entry_perm,
  input wire mpz_pkg::mpz_perm_t            lookup_perm,
  input wire logic [mpz_pkg::TAG_W-1:0]     process_tag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire logic rd = move_req.from_special;
  wire logic [15:0] sel = move_req.special_reg_select;
  // tag write lands in the low byte only
  property p_tag_wr; move_req.to_special && sel == 16'h1000 |=> process_tag == $past(move_req.wdata[7:0]); endproperty
  a_tag_wr: assert property (p_tag_wr) else $error("tag write not taken");
  // tag read returns the old tag with reserved bits clear
  property p_tag_rd; rd && sel == 16'h1000 |=> move_rdata == {24'h000000, $past(process_tag)}; endproperty
  a_tag_rd: assert property (p_tag_rd) else $error("tag read wrong");
  property p_zone_hit; rd && sel == 16'h1001 |=> move_hit; endproperty
  a_zone_hit: assert property (p_zone_hit) else $error("zone read no hit");
  property p_low_hit; rd && sel == 16'h1002 |=> move_hit; endproperty
  a_low_hit: assert property (p_low_hit) else $error("low read no hit");
  // unmapped selects answer nothing
  property p_unmapped; rd && !(sel inside {[16'h1000:16'h1004]}) |=> !move_hit && move_rdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped select answered");
  property p_idle; !rd |=> !move_hit && move_rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("answer without read");
  // zone overrides never create validity
  property p_valid; lookup_perm.valid |-> lookup_entry_perm.valid; endproperty
  a_valid: assert property (p_valid) else $error("validity granted");
  // an override of a valid entry grants store and fetch together
  property p_grant; lookup_perm.valid && lookup_perm.store != lookup_entry_perm.store |-> lookup_perm.store && lookup_perm.fetch; endproperty
  a_grant: assert property (p_grant) else $error("partial grant");
  // tag moves only on a move request
  property p_tag_hold; !move_req.to_special && !rd |=> $stable(process_tag); endproperty
  a_tag_hold: assert property (p_tag_hold) else $error("tag changed idle");
endmodule // mpz_regs_asserts
bind mpz_regs mpz_regs_asserts chk (.ref_clk(ref_clk), .nrst(nrst), .move_req(move_req),
  .move_rdata(move_rdata), .move_hit(move_hit), .lookup_entry_perm(lookup_entry_perm),
  .lookup_perm(lookup_perm), .process_tag(process_tag));
`default_nettype wire

//--- verif/test_mpz_regs.sv
// testbench: zone decode table, tag exchange, reset and buffer retention
`timescale 1ns/10ps
`default_nettype none
module test_mpz_regs;
  typedef struct packed { logic u; logic [5:0] i; logic [2:0] e; logic [2:0] x; } mpz_row_t;
  logic                ref_clk = 1'b0;
  logic                nrst    = 1'b0;
  logic                dbg_rst = 1'b0;
  mpz_pkg::mpz_move_t  mv      = '0;
  logic                user    = 1'b0;
  logic [5:0]          idx     = 6'h00;
  mpz_pkg::mpz_perm_t  eperm   = '0;
  logic [31:0]         rdata;
  logic [31:0]         rdata_two;
  logic                hit;
  mpz_pkg::mpz_perm_t  perm;
  logic [7:0]          tag;
  int                  fails = 0;
  int                  check_count = 0;
  int                  cycles = 0;
  // zone k of entry k holds field k; rows: user, entry, own perm, expected perm
  mpz_row_t rows [8] = '{'{1'b1, 6'h00, 3'h4, 3'h0}, '{1'b1, 6'h01, 3'h4, 3'h4},
    '{1'b1, 6'h02, 3'h6, 3'h6}, '{1'b1, 6'h03, 3'h4, 3'h7}, '{1'b0, 6'h00, 3'h5, 3'h5},
    '{1'b0, 6'h01, 3'h6, 3'h6}, '{1'b0, 6'h02, 3'h4, 3'h7}, '{1'b0, 6'h03, 3'h0, 3'h3}};
  mpz_regs dut (.ref_clk(ref_clk), .nrst(nrst), .debugger_reset_input(dbg_rst),
    .move_req(mv), .move_rdata(rdata), .move_hit(hit), .user_state_flag(user),
    .lookup_index(idx), .lookup_entry_perm(eperm), .lookup_perm(perm), .process_tag(tag));
  // two-zone build on the same moves: only zone fields 0 and 1 may hold bits
  mpz_regs #(.zone_count_param(2)) dut_two (.ref_clk(ref_clk), .nrst(nrst),
    .debugger_reset_input(dbg_rst), .move_req(mv), .move_rdata(rdata_two), .move_hit(),
    .user_state_flag(user), .lookup_index(idx), .lookup_entry_perm(eperm), .lookup_perm(),
    .process_tag());
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle strobe; the answer stands at the following falling edge
  task automatic move(input logic wr, input logic [15:0] sel, input logic [31:0] wd);
    @(negedge ref_clk);
    mv = '{to_special: wr, from_special: !wr, special_reg_select: sel, wdata: wd};
    @(negedge ref_clk);
    mv = '0;
  endtask
  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // hang guard, far above the roughly 60 cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      end_sim();
    end
  end
  initial begin
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    move(1'b1, 16'h1004, 32'h5);
    move(1'b0, 16'h1002, 32'h0);
    cmp_word(rdata, 32'h0);
    move(1'b1, 16'h1001, 32'h1b00_0000);
    for (int k = 0; k < 4; k++) begin
      move(1'b1, 16'h1004, 32'(k));
      move(1'b1, 16'h1002, 32'(k << 4));
    end
    foreach (rows[n]) begin
      @(negedge ref_clk);
      user = rows[n].u;
      idx = rows[n].i;
      eperm = rows[n].e;
      #10 cmp_word({29'h0, perm}, {29'h0, rows[n].x});
    end
    move(1'b0, 16'h1001, 32'h0);
    cmp_word({hit, rdata[30:0]}, 32'h9b00_0000);
    cmp_word(rdata, 32'h1b00_0000);
    cmp_word(rdata_two, 32'h1000_0000);
    move(1'b1, 16'h1000, 32'hffff_ffa5);
    cmp_word({24'h0, tag}, 32'ha5);
    move(1'b0, 16'h1000, 32'h0);
    cmp_word(rdata, 32'ha5);
    // tag saved into entry 2 on a high write, restored by a high read
    move(1'b1, 16'h1004, 32'h2);
    move(1'b1, 16'h1000, 32'h3c);
    move(1'b1, 16'h1003, 32'h0);
    move(1'b1, 16'h1000, 32'h77);
    move(1'b0, 16'h1003, 32'h0);
    cmp_word({24'h0, tag}, 32'h3c);
    move(1'b0, 16'h1005, 32'h0);
    cmp_word({hit, rdata[30:0]}, 32'h0);
    // nrst clears registers, with the unconnected debugger reset pulsed too; buffer words are kept
    @(negedge ref_clk);
    dbg_rst = 1'b1;
    nrst = 1'b0;
    @(negedge ref_clk);
    dbg_rst = 1'b0;
    nrst = 1'b1;
    move(1'b0, 16'h1000, 32'h0);
    cmp_word(rdata, 32'h0);
    move(1'b0, 16'h1001, 32'h0);
    cmp_word(rdata, 32'h0);
    move(1'b1, 16'h1004, 32'h3);
    move(1'b0, 16'h1002, 32'h0);
    cmp_word(rdata, 32'h30);
    end_sim();
  end
endmodule // test_mpz_regs
`default_nettype wire
